/* sync_serial_pkg.sv */
// Constants, types and state layout for the two-wire serial slave port.
// Assumes one 200 MHz core clock and a classic Wishbone register bus.
//
// Contract
// - Slave transmit drives the data line whatever the direction bits hold.
// - Matched address or following data byte is acknowledged and buffered automatically.
// - Buffer full or overflow set: no acknowledge, no load, interrupt flag still set.
// - Buffer read clears buffer full; overflow clears only by software write.
// - After enable, wait for START, then shift eight bits on rising clock edges.
// - Shift bits 7 to 1 compared with slave address at eighth falling edge.
// - Match with flags clear: load, buffer full, acknowledge, interrupt at ninth fall.
// - High ten-bit byte sets flags, update needed, stretches clock until address write.
// - Low ten-bit byte sets flags again; restoring high byte releases the clock.
// - Repeated START read of high byte sets only interrupt and buffer full.
// - Start and stop bits clear on reset or disable, follow bus conditions.
// - Interrupt flag set on every byte moved, and on START and STOP in modes 1011, 1110 and 1111.
// - Pin switched to output in master operation is driven low.
// - Mode 1011 idles slave reception; only start/stop and byte interrupts.
// - Interrupt enabled while bus busy raises the interrupt at next STOP.
// - Slave logic keeps receiving after lost arbitration and acknowledges if addressed.
// - Read/write bit holds last matched direction until START or STOP.
// - Data/address bit is one after data, zero after an address.

package sync_serial_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_DATA_BUF = 8'h13;
  localparam logic [7:0] IDX_CONTROL = 8'h14;
  localparam logic [7:0] IDX_DIRECTION = 8'h87;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_SLAVE_ADDR = 8'h93;
  localparam logic [7:0] IDX_STATUS = 8'h94;

  // ****************************************************************
  // Field positions, masks and reset values.
  // ****************************************************************
  localparam int PORT_IRQ_BIT = 3;
  localparam int SCL_DIR_BIT = 3;
  localparam int SDA_DIR_BIT = 4;
  localparam logic [7:0] IRQ_FLAGS_MASK = 8'hbf;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hff;
  localparam logic [7:0] RST_SLAVE_ADDR = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

  // ****************************************************************
  // Modes of the control register mode field.
  // ****************************************************************
  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE10 = 4'h7;
  localparam logic [3:0] MODE_FW_MASTER = 4'hb;
  localparam logic [3:0] MODE_SLAVE7_SS = 4'he;
  localparam logic [3:0] MODE_SLAVE10_SS = 4'hf;

  // ****************************************************************
  // Byte engine states, Gray coded along idle, address, ack, data.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_TX = 3'h6,
    ST_TXACK = 3'h7,
    ST_LISTEN = 3'h5
  } byte_state_t;

  // All state of the port in one record.
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    byte_state_t st;
    logic [3:0] bits;
    logic [7:0] serial_shift_register;
    logic [7:0] serial_data_buffer;
    logic [7:0] slave_address;
    logic [7:0] port_c_direction;
    logic [7:0] peripheral_irq_flags;
    logic [7:0] peripheral_irq_enables;
    logic write_collision_flag;
    logic rx_overflow_flag;
    logic port_enable_bit;
    logic clock_polarity_bit;
    logic [3:0] port_mode_field;
    logic data_flag;
    logic stop_seen;
    logic start_seen;
    logic rw_flag;
    logic addr_update_needed;
    logic buffer_full_flag;
    logic ack_drive;
    logic irq_pend;
    logic go_tx;
    logic low_pending;
    logic ten_ok;
    logic tx_loaded;
    logic tx_nak;
    logic stop_arm;
    logic wb_ack;
    logic [7:0] wb_rdat;
  } port_state_t;

endpackage : sync_serial_pkg

/* sync_serial_i2c_slave_port.sv */
// Two-wire serial port in its slave role, with firmware master support.
// Assumes open-drain pins resolved outside and a classic Wishbone master.
`timescale 1ns/1ps
`default_nettype none

module sync_serial_i2c_slave_port (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register bus.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Two-wire bus pins.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  // ****************************************************************
  // State and decoded events.
  // ****************************************************************
  sync_serial_pkg::port_state_t r;
  sync_serial_pkg::port_state_t next_r;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic wb_take;
  logic wb_wr;
  logic wb_rd;
  logic [7:0] wb_idx;
  logic slave_on;
  logic ten_bit;
  logic ss_irq;
  logic listen;
  logic byte_done;
  logic tx_low;
  logic scl_hold;

  // Only the second synchroniser stage and its delayed copy feed edge logic.
  assign scl_s = r.scl_sync[1];
  assign sda_s = r.sda_sync[1];
  assign scl_rise = scl_s & ~r.scl_q;
  assign scl_fall = ~scl_s & r.scl_q;
  assign start_ev = scl_s & r.scl_q & r.sda_q & ~sda_s;
  assign stop_ev = scl_s & r.scl_q & ~r.sda_q & sda_s;
  assign byte_done = scl_fall & (r.bits == sync_serial_pkg::BITS_PER_BYTE);

  // Mode decode.
  assign slave_on = r.port_enable_bit & ((r.port_mode_field == sync_serial_pkg::MODE_SLAVE7) |
    (r.port_mode_field == sync_serial_pkg::MODE_SLAVE10) |
    (r.port_mode_field == sync_serial_pkg::MODE_SLAVE7_SS) |
    (r.port_mode_field == sync_serial_pkg::MODE_SLAVE10_SS));
  assign ten_bit = (r.port_mode_field == sync_serial_pkg::MODE_SLAVE10) |
    (r.port_mode_field == sync_serial_pkg::MODE_SLAVE10_SS);
  assign ss_irq = (r.port_mode_field == sync_serial_pkg::MODE_FW_MASTER) |
    (r.port_mode_field == sync_serial_pkg::MODE_SLAVE7_SS) |
    (r.port_mode_field == sync_serial_pkg::MODE_SLAVE10_SS);
  assign listen = r.port_enable_bit & (r.port_mode_field == sync_serial_pkg::MODE_FW_MASTER);

  // Bus request decode; the answer follows one cycle after the request appears.
  assign wb_take = wb_cyc_i & wb_stb_i & ~r.wb_ack;
  assign wb_wr = wb_take & wb_we_i & wb_sel_i[0];
  assign wb_rd = wb_take & ~wb_we_i;
  assign wb_idx = wb_adr_i[9:2];

  // ****************************************************************
  // Pin drive.
  // ****************************************************************
  // A one is sent by releasing the pin; the update stretch waits for the ninth clock so the master can end it.
  assign tx_low = (r.st == sync_serial_pkg::ST_TX) & r.tx_loaded & ~r.serial_shift_register[7];
  assign scl_hold = r.port_enable_bit & ((r.addr_update_needed & (r.st != sync_serial_pkg::ST_ACK)) |
    ((r.st == sync_serial_pkg::ST_TX) & ~r.clock_polarity_bit));
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  // Slave drive overrides an input direction; an output direction drives low.
  assign scl_oe_o = ~r.port_c_direction[sync_serial_pkg::SCL_DIR_BIT] | scl_hold;
  assign sda_oe_o = ~r.port_c_direction[sync_serial_pkg::SDA_DIR_BIT] | r.ack_drive | tx_low;
  assign wb_ack_o = r.wb_ack;
  assign wb_dat_o = {24'h000000, r.wb_rdat};

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // Software effects are applied first so that a hardware set in the same cycle wins.
  always_comb begin
    logic match;
    logic ua_set;
    logic hi_ok;
    match = 1'b0;
    ua_set = 1'b0;
    hi_ok = 1'b0;
    next_r = r;
    next_r.scl_sync = {r.scl_sync[0], scl_i};
    next_r.sda_sync = {r.sda_sync[0], sda_i};
    next_r.scl_q = scl_s;
    next_r.sda_q = sda_s;
    next_r.wb_ack = wb_take;

    // Register reads; unmapped indices read as zero.
    if (wb_rd) begin
      case (wb_idx)
        sync_serial_pkg::IDX_IRQ_FLAGS: next_r.wb_rdat = r.peripheral_irq_flags;
        sync_serial_pkg::IDX_DATA_BUF: begin
          next_r.wb_rdat = r.serial_data_buffer;
          next_r.buffer_full_flag = 1'b0;
        end
        sync_serial_pkg::IDX_CONTROL: next_r.wb_rdat = {r.write_collision_flag, r.rx_overflow_flag,
          r.port_enable_bit, r.clock_polarity_bit, r.port_mode_field};
        sync_serial_pkg::IDX_DIRECTION: next_r.wb_rdat = r.port_c_direction;
        sync_serial_pkg::IDX_IRQ_ENABLES: next_r.wb_rdat = r.peripheral_irq_enables;
        sync_serial_pkg::IDX_SLAVE_ADDR: next_r.wb_rdat = r.slave_address;
        sync_serial_pkg::IDX_STATUS: next_r.wb_rdat = {2'b00, r.data_flag, r.stop_seen, r.start_seen,
          r.rw_flag, r.addr_update_needed, r.buffer_full_flag};
        default: next_r.wb_rdat = 8'h00;
      endcase
    end

    // Register writes.
    if (wb_wr) begin
      case (wb_idx)
        sync_serial_pkg::IDX_IRQ_FLAGS: next_r.peripheral_irq_flags = wb_dat_i[7:0] &
          sync_serial_pkg::IRQ_FLAGS_MASK;
        sync_serial_pkg::IDX_DATA_BUF: begin
          // A write while a byte is shifting out is refused and flagged.
          if ((r.st == sync_serial_pkg::ST_TX) && (r.bits != 4'h0)) begin
            next_r.write_collision_flag = 1'b1;
          end else begin
            next_r.serial_data_buffer = wb_dat_i[7:0];
            next_r.buffer_full_flag = 1'b1;
          end
        end
        sync_serial_pkg::IDX_CONTROL: begin
          next_r.write_collision_flag = wb_dat_i[7];
          next_r.rx_overflow_flag = wb_dat_i[6];
          next_r.port_enable_bit = wb_dat_i[5];
          next_r.clock_polarity_bit = wb_dat_i[4];
          next_r.port_mode_field = wb_dat_i[3:0];
        end
        sync_serial_pkg::IDX_DIRECTION: next_r.port_c_direction = wb_dat_i[7:0];
        sync_serial_pkg::IDX_IRQ_ENABLES: begin
          next_r.peripheral_irq_enables = wb_dat_i[7:0] & sync_serial_pkg::IRQ_FLAGS_MASK;
          // Enabling while the bus is busy promises an interrupt at the next stop.
          if (wb_dat_i[sync_serial_pkg::PORT_IRQ_BIT] &&
              !r.peripheral_irq_enables[sync_serial_pkg::PORT_IRQ_BIT] && r.start_seen) begin
            next_r.stop_arm = 1'b1;
          end
        end
        sync_serial_pkg::IDX_SLAVE_ADDR: begin
          next_r.slave_address = wb_dat_i[7:0];
          next_r.addr_update_needed = 1'b0;
        end
        default: ;
      endcase
    end

    // Bus conditions and the byte engine.
    if (!r.port_enable_bit) begin
      next_r.start_seen = 1'b0;
      next_r.stop_seen = 1'b0;
      next_r.st = sync_serial_pkg::ST_IDLE;
      next_r.ack_drive = 1'b0;
      next_r.ten_ok = 1'b0;
      next_r.low_pending = 1'b0;
      next_r.addr_update_needed = 1'b0;
      next_r.stop_arm = 1'b0;
    end else if (start_ev) begin
      next_r.start_seen = 1'b1;
      next_r.stop_seen = 1'b0;
      next_r.rw_flag = 1'b0;
      next_r.ack_drive = 1'b0;
      next_r.bits = 4'h0;
      next_r.tx_loaded = 1'b0;
      next_r.low_pending = 1'b0;
      if (ss_irq) begin
        next_r.peripheral_irq_flags[sync_serial_pkg::PORT_IRQ_BIT] = 1'b1;
      end
      // Wait for START before shifting; slave-idle mode only counts bytes.
      if (slave_on) begin
        next_r.st = sync_serial_pkg::ST_ADDR;
      end else if (listen) begin
        next_r.st = sync_serial_pkg::ST_LISTEN;
      end else begin
        next_r.st = sync_serial_pkg::ST_IDLE;
      end
    end else if (stop_ev) begin
      next_r.stop_seen = 1'b1;
      next_r.start_seen = 1'b0;
      next_r.rw_flag = 1'b0;
      next_r.ack_drive = 1'b0;
      next_r.ten_ok = 1'b0;
      next_r.low_pending = 1'b0;
      next_r.stop_arm = 1'b0;
      next_r.st = sync_serial_pkg::ST_IDLE;
      if (ss_irq || r.stop_arm) begin
        next_r.peripheral_irq_flags[sync_serial_pkg::PORT_IRQ_BIT] = 1'b1;
      end
    end else begin
      case (r.st)
        sync_serial_pkg::ST_ADDR, sync_serial_pkg::ST_RX, sync_serial_pkg::ST_LISTEN: begin
          // Bits are taken on the rising edge of the bus clock.
          if (scl_rise && (r.bits < sync_serial_pkg::BITS_PER_BYTE)) begin
            next_r.serial_shift_register = {r.serial_shift_register[6:0], sda_s};
            next_r.bits = r.bits + 4'h1;
          end
          if (byte_done) begin
            next_r.irq_pend = 1'b1;
            next_r.go_tx = 1'b0;
            next_r.st = sync_serial_pkg::ST_ACK;
            hi_ok = (r.serial_shift_register[7:3] == sync_serial_pkg::TEN_BIT_PREFIX) &&
              (r.serial_shift_register[2:1] == r.slave_address[2:1]);
            if (r.st == sync_serial_pkg::ST_LISTEN) begin
              next_r.data_flag = 1'b1;
            end else if (r.st == sync_serial_pkg::ST_ADDR) begin
              // Address byte: seven-bit compare, or first ten-bit byte.
              if (!ten_bit) begin
                match = r.serial_shift_register[7:1] == r.slave_address[7:1];
              end else if (r.serial_shift_register[0]) begin
                match = hi_ok && r.ten_ok;
              end else begin
                match = hi_ok;
                ua_set = hi_ok;
              end
            end else if (r.low_pending) begin
              match = r.serial_shift_register == r.slave_address;
              ua_set = match;
            end else begin
              match = 1'b1;
              next_r.data_flag = 1'b1;
            end
            if ((r.st != sync_serial_pkg::ST_LISTEN) && !match) begin
              // Not addressed: stay silent until the next start.
              next_r.irq_pend = 1'b0;
              next_r.st = sync_serial_pkg::ST_IDLE;
            end else if (r.st != sync_serial_pkg::ST_LISTEN) begin
              if ((r.st == sync_serial_pkg::ST_ADDR) || r.low_pending) begin
                next_r.data_flag = 1'b0;
                next_r.rw_flag = r.serial_shift_register[0];
                next_r.go_tx = r.serial_shift_register[0];
              end
              next_r.low_pending = ten_bit && (r.st == sync_serial_pkg::ST_ADDR) &&
                !r.serial_shift_register[0];
              if (r.low_pending) begin
                next_r.ten_ok = 1'b1;
              end
              if (ua_set) begin
                next_r.addr_update_needed = 1'b1;
              end
              // The slave answers whatever it did on the bus before, even after lost arbitration.
              if (!r.buffer_full_flag && !r.rx_overflow_flag) begin
                next_r.serial_data_buffer = r.serial_shift_register;
                next_r.buffer_full_flag = 1'b1;
                next_r.ack_drive = 1'b1;
              end else begin
                next_r.go_tx = 1'b0;
                next_r.rx_overflow_flag = r.rx_overflow_flag | r.buffer_full_flag;
              end
            end
          end
        end
        sync_serial_pkg::ST_ACK: begin
          // Ninth falling edge ends the acknowledge and raises the flag.
          if (scl_fall) begin
            next_r.ack_drive = 1'b0;
            next_r.irq_pend = 1'b0;
            next_r.bits = 4'h0;
            if (r.irq_pend) begin
              next_r.peripheral_irq_flags[sync_serial_pkg::PORT_IRQ_BIT] = 1'b1;
            end
            if (listen) begin
              next_r.st = sync_serial_pkg::ST_LISTEN;
            end else if (r.go_tx) begin
              next_r.st = sync_serial_pkg::ST_TX;
              next_r.clock_polarity_bit = 1'b0;
              next_r.tx_loaded = 1'b0;
            end else begin
              next_r.st = sync_serial_pkg::ST_RX;
            end
          end
        end
        sync_serial_pkg::ST_TX: begin
          // The clock is held low until software releases it; the byte is taken then.
          if (!r.tx_loaded && r.clock_polarity_bit) begin
            next_r.serial_shift_register = r.serial_data_buffer;
            next_r.tx_loaded = 1'b1;
          end else if (r.tx_loaded && scl_fall) begin
            next_r.serial_shift_register = {r.serial_shift_register[6:0], 1'b1};
            next_r.bits = r.bits + 4'h1;
            if (r.bits == (sync_serial_pkg::BITS_PER_BYTE - 4'h1)) begin
              next_r.st = sync_serial_pkg::ST_TXACK;
              next_r.tx_loaded = 1'b0;
              next_r.buffer_full_flag = 1'b0;
              next_r.data_flag = 1'b1;
            end
          end
        end
        sync_serial_pkg::ST_TXACK: begin
          // The master's acknowledge decides whether another byte follows.
          if (scl_rise) begin
            next_r.tx_nak = sda_s;
          end
          if (scl_fall) begin
            next_r.peripheral_irq_flags[sync_serial_pkg::PORT_IRQ_BIT] = 1'b1;
            next_r.bits = 4'h0;
            next_r.clock_polarity_bit = r.tx_nak;
            next_r.st = r.tx_nak ? sync_serial_pkg::ST_IDLE : sync_serial_pkg::ST_TX;
          end
        end
        default: next_r.st = sync_serial_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Synchronous reset; the data buffer has no documented reset and is cleared anyway.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.scl_sync <= 2'b11;
      r.sda_sync <= 2'b11;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.st <= sync_serial_pkg::ST_IDLE;
      r.serial_data_buffer <= sync_serial_pkg::RST_BYTE;
      r.slave_address <= sync_serial_pkg::RST_SLAVE_ADDR;
      r.port_c_direction <= sync_serial_pkg::RST_DIRECTION;
      r.peripheral_irq_flags <= sync_serial_pkg::RST_IRQ_FLAGS;
      r.peripheral_irq_enables <= sync_serial_pkg::RST_IRQ_ENABLES;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  buf_read_clear_a: assert property (
    (wb_rd && (wb_idx == sync_serial_pkg::IDX_DATA_BUF) && !byte_done && !start_ev)
      |=> !r.buffer_full_flag)
    else $error("Buffer read did not clear buffer full.");

  ovf_sw_only_a: assert property (
    $fell(r.rx_overflow_flag) |-> $past(wb_wr && (wb_idx == sync_serial_pkg::IDX_CONTROL)))
    else $error("Overflow flag cleared without a control write.");

  full_no_ack_a: assert property (
    (byte_done && (r.st == sync_serial_pkg::ST_RX) && !r.low_pending &&
      (r.buffer_full_flag || r.rx_overflow_flag))
      |=> !r.ack_drive && $stable(r.serial_data_buffer) && r.irq_pend)
    else $error("Byte accepted while buffer full or overflowed.");

  ack_ninth_irq_a: assert property (
    (r.ack_drive && r.irq_pend && scl_fall && !start_ev && !stop_ev)
      |=> !r.ack_drive && r.peripheral_irq_flags[sync_serial_pkg::PORT_IRQ_BIT])
    else $error("Acknowledge did not end with interrupt at ninth fall.");

  start_bits_a: assert property (
    (r.port_enable_bit && start_ev) |=> r.start_seen && !r.stop_seen && !r.rw_flag)
    else $error("Start condition not recorded.");

  disable_clear_a: assert property (
    !r.port_enable_bit |=> !r.start_seen && !r.stop_seen)
    else $error("Start or stop bit survived disable.");

  master_drive_low_a: assert property (
    !r.port_c_direction[sync_serial_pkg::SDA_DIR_BIT] |-> sda_oe_o && !sda_o)
    else $error("Output-configured data pin not driven low.");

  ack_override_a: assert property (
    (r.ack_drive || tx_low) |-> sda_oe_o ##1 (r.ack_drive || tx_low || scl_fall || $past(scl_fall)
      || !r.port_enable_bit || $past(start_ev || stop_ev || wb_wr || r.tx_loaded)))
    else $error("Slave drive not visible on the data pin.");

  update_stretch_a: assert property (
    (r.port_enable_bit && r.addr_update_needed && (r.st != sync_serial_pkg::ST_ACK)) |-> scl_oe_o)
    else $error("Clock not held while address update is pending.");

  fw_stop_irq_a: assert property (
    (listen && stop_ev) |=> r.peripheral_irq_flags[sync_serial_pkg::PORT_IRQ_BIT] && r.stop_seen)
    else $error("Stop in firmware master mode raised no interrupt.");

  rw_on_start_a: assert property (
    (r.port_enable_bit && (start_ev || stop_ev)) |=> !r.rw_flag)
    else $error("Read/write bit not cleared on start or stop.");

endmodule : sync_serial_i2c_slave_port

`default_nettype wire

/* i2c_master_model.sv */
// Two-wire bus master model: frames bytes at a 160 ns bus clock.
// Assumes pull-ups on both lines and the 5 ns core clock for pacing.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Core clock and resolved lines.
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  // Pull-low drives, high pulls the line down.
  output logic scl_low_o,
  output logic sda_low_o
);
  initial {scl_low_o, sda_low_o} = 2'b00;
  // Quarter bus period; lines only move just after a core edge.
  task automatic q();
    repeat (8) @(posedge clk_i);
  endtask
  // Releasing the clock must wait out a slave that stretches it.
  task automatic rise();
    scl_low_o <= 1'b0;
    q();
    while (scl_i !== 1'b1) @(posedge clk_i);
  endtask
  // Called from idle, after our own stop, or after a byte for a repeated START.
  task automatic start();
    sda_low_o <= 1'b0;
    q();
    rise();
    sda_low_o <= 1'b1;
    q();
    scl_low_o <= 1'b1;
    q();
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    q();
    rise();
    sda_low_o <= 1'b0;
    q();
  endtask
  // One bit: data set while clock low, line read in mid high.
  task automatic bit_io(input logic b, output logic s);
    sda_low_o <= !b;
    q();
    rise();
    // A one is only ever a release, so a low seen while sending one means another driver won.
    s = sda_i;
    q();
    scl_low_o <= 1'b1;
    q();
  endtask
  // Eight bits MSB first, then the line is released for the slave's answer.
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* sync_serial_i2c_slave_port_tb.sv */
// Self-checking bench for the slave port: register bus and two-wire transfers.
// Assumes the master model file and pull-ups resolved here.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_i2c_slave_port_tb;
  logic clk_i, rst_i, cyc, stb, we, scl_low, sda_low, ack, scl_oe, sda_oe, a;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0] r;
  int err_total, comparisons;
  // Open-drain lines: either party pulling wins, else the pull-up.
  wire scl = !(scl_low || scl_oe);
  wire sda = !(sda_low || sda_oe);
  sync_serial_i2c_slave_port DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl), .scl_o(),
    .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
  i2c_master_model M (.clk_i(clk_i), .scl_i(scl), .sda_i(sda), .scl_low_o(scl_low), .sda_low_o(sda_low));
  // ****************************************
  // Clock, bus access and comparison helpers.
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = !clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; the request is held until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n == 50) err_total++;
    r = rdat[7:0];
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic reset_values();
    logic [7:0] idx [7] = '{8'h0c, 8'h14, 8'h87, 8'h8c, 8'h93, 8'h94, 8'h20};
    logic [7:0] exp [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    foreach (idx[i]) begin
      wb(1'b0, idx[i], 8'h00);
      chk(r, exp[i]);
    end
  endtask
  task automatic addr_match();
    wb(1'b1, 8'h93, 8'ha4);
    wb(1'b1, 8'h14, 8'h26);
    M.start();
    M.xfer(8'ha4, a);
    chk({7'h0, a}, 8'h01);
    wb(1'b0, 8'h0c, 8'h00);
    chk(r, 8'h08);
    wb(1'b0, 8'h94, 8'h00);
    chk(r, 8'h09);
    wb(1'b0, 8'h13, 8'h00);
    chk(r, 8'ha4);
    wb(1'b0, 8'h94, 8'h00);
    chk(r, 8'h08);
  endtask
  // Second byte arrives unread, so it is refused but still flagged.
  task automatic data_overrun();
    wb(1'b1, 8'h0c, 8'h00);
    M.xfer(8'h5a, a);
    chk({7'h0, a}, 8'h01);
    wb(1'b0, 8'h94, 8'h00);
    chk(r, 8'h29);
    wb(1'b1, 8'h0c, 8'h00);
    M.xfer(8'h33, a);
    chk({7'h0, a}, 8'h00);
    wb(1'b0, 8'h0c, 8'h00);
    chk(r, 8'h08);
    wb(1'b0, 8'h14, 8'h00);
    chk(r, 8'h66);
    wb(1'b0, 8'h13, 8'h00);
    chk(r, 8'h5a);
    M.stop();
    wb(1'b0, 8'h94, 8'h00);
    chk(r & 8'h19, 8'h10);
  endtask
  task automatic mismatch();
    wb(1'b1, 8'h14, 8'h26);
    wb(1'b1, 8'h0c, 8'h00);
    M.start();
    M.xfer(8'h10, a);
    chk({7'h0, a}, 8'h00);
    wb(1'b0, 8'h0c, 8'h00);
    chk(r, 8'h00);
    M.stop();
  endtask
  // Ten-bit address: high byte, low byte under a stretched clock, then a repeated START read.
  task automatic ten_bit_addr();
    wb(1'b1, 8'h93, 8'hf2);
    wb(1'b1, 8'h14, 8'h27);
    wb(1'b1, 8'h0c, 8'h00);
    M.start();
    M.xfer(8'hf2, a);
    chk({7'h0, a}, 8'h01);
    wb(1'b0, 8'h94, 8'h00);
    chk(r, 8'h0b);
    wb(1'b0, 8'h13, 8'h00);
    fork
      M.xfer(8'h5c, a);
      wb(1'b1, 8'h93, 8'h5c);
    join
    chk({7'h0, a}, 8'h01);
    wb(1'b0, 8'h94, 8'h00);
    chk(r, 8'h0b);
    wb(1'b0, 8'h13, 8'h00);
    chk(r, 8'h5c);
    wb(1'b1, 8'h0c, 8'h00);
    fork
      M.start();
      wb(1'b1, 8'h93, 8'hf2);
    join
    M.xfer(8'hf3, a);
    chk({7'h0, a}, 8'h01);
    wb(1'b0, 8'h94, 8'h00);
    chk(r, 8'h0d);
    wb(1'b0, 8'h0c, 8'h00);
    chk(r, 8'h08);
    // Disabling drops the transmit stretch so the bus can be stopped.
    wb(1'b1, 8'h14, 8'h00);
    M.stop();
  endtask
  // Firmware master mode: no slave answer, but START, byte and STOP all interrupt.
  task automatic fw_master();
    wb(1'b1, 8'h14, 8'h2b);
    M.start();
    wb(1'b0, 8'h0c, 8'h00);
    chk(r, 8'h08);
    wb(1'b1, 8'h0c, 8'h00);
    M.xfer(8'ha4, a);
    chk({7'h0, a}, 8'h00);
    wb(1'b0, 8'h0c, 8'h00);
    chk(r, 8'h08);
    wb(1'b1, 8'h0c, 8'h00);
    M.stop();
    wb(1'b0, 8'h0c, 8'h00);
    chk(r, 8'h08);
  endtask
  task automatic complete_run();
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence after a 16-cycle reset.
  initial begin
    {err_total, comparisons} = 64'h0;
    {rst_i, cyc, stb, we, adr, wdat} <= {1'b1, 45'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Both pin directions stay at their all-input reset value for slave work.
    reset_values();
    addr_match();
    data_overrun();
    ten_bit_addr();
    mismatch();
    fw_master();
    complete_run();
  end
  // Watchdog: the whole run needs well under 40 us.
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule // sync_serial_i2c_slave_port_tb
`default_nettype wire
